// ### src/cpr_core_regs.sv
// Core register set: program counter, accumulator, index, stack pointer, flags
//
// How it works
// [RULE_01] Eight-bit core with separate program and data spaces, five core registers.
// [RULE_02] Core registers reach only the execution unit, never the mapped register space.
// [RULE_03] Sixteen-bit program counter covers program memory flat, no paging.
// [RULE_04] Accumulator takes every arithmetic or logic result of a source-mode instruction.
// [RULE_05] Index register supplies the offset added in indexed addressing.
// [RULE_06] Stack pointer moves on push, pop, call, long call, returns, swap, add.
// [RULE_07] Flags: enable bit 0, zero bit 1, carry bit 2, supervisor bit 3, bank bit 4.
// [RULE_08] Zero flag is one after a zero result, else zero.
// [RULE_09] Carry flag is one after a carry, else zero.
// [RULE_10] Supervisor flag is zero in user code, one in supervisor code.
// [RULE_11] User writes to the flags leave the supervisor bit untouched.
// [RULE_12] Global interrupt enable gates every interrupt.
// [RULE_13] Bank bit selects register bank zero or one.
// [RULE_14] Flags are set or cleared explicitly only by logic instructions on them.
// [RULE_15] Each arithmetic, logic or shift instruction chooses which flags it updates.
// [RULE_16] Reset clears everything except the zero flag, which sets; bits 7..5 read zero.
//
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/1ps
module cpr_core_regs #(
    parameter int DATA_W = cpr_pkg::DATA_W,
    parameter int PC_W = cpr_pkg::PC_W,
    parameter int PROG_BYTES = cpr_pkg::PROG_BYTES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic clk_en,
    // Execution unit access port
    input wire logic [cpr_pkg::SEL_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    // ALU results
    input wire logic alu_wr,
    input wire logic alu_to_acc,
    input wire logic alu_zero_en,
    input wire logic alu_carry_en,
    input wire logic [DATA_W-1:0] alu_result,
    input wire logic alu_carry,
    // Logic instruction on the flags
    input wire logic f_logic_wr,
    input wire cpr_pkg::cpr_logic_op_t f_logic_op,
    input wire logic [DATA_W-1:0] f_operand,
    // Supervisor entry and exit
    input wire logic super_enter,
    input wire logic super_exit,
    // Program counter control
    input wire logic pc_load,
    input wire logic [PC_W-1:0] pc_target,
    input wire logic [cpr_pkg::STEP_W-1:0] pc_step,
    // Stack pointer control
    input wire cpr_pkg::cpr_sp_op_t sp_op,
    input wire logic [DATA_W-1:0] sp_operand,
    // Indexed addressing
    input wire logic [DATA_W-1:0] idx_offset,
    output logic [DATA_W-1:0] idx_addr,
    // Interrupt gating
    input wire logic irq_pending,
    output logic irq_take,
    // Register state
    output logic [PC_W-1:0] program_counter_reg,
    output logic [DATA_W-1:0] top_of_stack_pointer,
    output logic [DATA_W-1:0] result_accumulator,
    output logic [DATA_W-1:0] index_offset,
    output logic [DATA_W-1:0] processor_flags,
    output logic global_interrupt_enable,
    output logic register_bank_select,
    output logic zero_flag,
    output logic carry_flag,
    output logic supervisor_state
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (DATA_W != cpr_pkg::DATA_W) // RULE_01
    begin : g_bad_data_w
        $error("cpr_core_regs: data path must be eight bits");
    end
    if ((2 ** PC_W) < PROG_BYTES) // RULE_03
    begin : g_bad_pc_w
        $error("cpr_core_regs: program counter too narrow for program memory");
    end

    // ------------------------------------------------------------------
    // Accumulator and index register
    // ------------------------------------------------------------------
    logic acc_load;
    logic [DATA_W-1:0] acc_next;
    logic idx_load;
    logic [DATA_W-1:0] acc_q;
    logic [DATA_W-1:0] idx_q;

    // The ALU wins over a plain move in the same cycle
    always_comb
    begin
        acc_load = 1'b0;
        acc_next = reg_wdata;
        if (alu_wr && alu_to_acc) // RULE_04
        begin
            acc_load = 1'b1;
            acc_next = alu_result;
        end
        else if (reg_wr && reg_addr == cpr_pkg::SEL_ACC)
        begin
            acc_load = 1'b1;
        end
        idx_load = reg_wr && reg_addr == cpr_pkg::SEL_IDX;
    end

    cpr_hold_reg #(
        .WIDTH(DATA_W),
        .RESET_VAL(cpr_pkg::ACC_RESET)
    ) u_acc (
        .clk(clk),
        .rst(rst),
        .clk_en(clk_en),
        .load(acc_load),
        .d(acc_next),
        .q(acc_q)
    );

    cpr_hold_reg #(
        .WIDTH(DATA_W),
        .RESET_VAL(cpr_pkg::IDX_RESET)
    ) u_idx (
        .clk(clk),
        .rst(rst),
        .clk_en(clk_en),
        .load(idx_load),
        .d(reg_wdata),
        .q(idx_q)
    );

    assign result_accumulator = acc_q;
    assign index_offset = idx_q;

    // ------------------------------------------------------------------
    // Flags register
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] flags_d;
    logic [DATA_W-1:0] flags_q;
    logic [DATA_W-1:0] logic_res;

    always_comb
    begin
        unique case (f_logic_op)
            cpr_pkg::CPR_LOGIC_AND: logic_res = flags_q & f_operand;
            cpr_pkg::CPR_LOGIC_OR: logic_res = flags_q | f_operand;
            cpr_pkg::CPR_LOGIC_XOR: logic_res = flags_q ^ f_operand;
            cpr_pkg::CPR_LOGIC_MOV: logic_res = f_operand;
        endcase
        flags_d = flags_q;
        // An explicit write through the access port never reaches the flags
        if (f_logic_wr) // RULE_14
        begin
            // Supervisor and reserved bits are masked off the user path
            flags_d = (logic_res & cpr_pkg::FLAGS_USER_MASK)
                    | (flags_q & ~cpr_pkg::FLAGS_USER_MASK); // RULE_11
        end
        else if (alu_wr) // RULE_15
        begin
            if (alu_zero_en)
            begin
                flags_d[cpr_pkg::FLAG_ZERO] = (alu_result == cpr_pkg::DATA_ZERO); // RULE_08
            end
            if (alu_carry_en)
            begin
                flags_d[cpr_pkg::FLAG_CARRY] = alu_carry; // RULE_09
            end
        end
        // Mode changes come only from the sequencer, entry wins over exit
        if (super_enter) // RULE_10
        begin
            flags_d[cpr_pkg::FLAG_SUPER] = 1'b1;
        end
        else if (super_exit)
        begin
            flags_d[cpr_pkg::FLAG_SUPER] = 1'b0;
        end
        flags_d = flags_d & cpr_pkg::FLAGS_IMPL_MASK; // RULE_16
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            flags_q <= cpr_pkg::FLAGS_RESET; // RULE_16
        end
        else if (clk_en)
        begin
            flags_q <= flags_d;
        end
    end

    assign processor_flags = flags_q;
    assign global_interrupt_enable = flags_q[cpr_pkg::FLAG_GIE]; // RULE_07
    assign zero_flag = flags_q[cpr_pkg::FLAG_ZERO];
    assign carry_flag = flags_q[cpr_pkg::FLAG_CARRY];
    assign supervisor_state = flags_q[cpr_pkg::FLAG_SUPER];
    assign register_bank_select = flags_q[cpr_pkg::FLAG_BANK]; // RULE_13

    // ------------------------------------------------------------------
    // Program counter and stack pointer
    // ------------------------------------------------------------------
    logic [PC_W-1:0] pc_d;
    logic [PC_W-1:0] pc_q;
    logic [DATA_W-1:0] sp_d;
    logic [DATA_W-1:0] sp_q;

    always_comb
    begin
        pc_d = pc_q;
        // Plain binary wrap: one flat space, no page register
        if (pc_load) // RULE_03
        begin
            pc_d = pc_target;
        end
        else
        begin
            pc_d = pc_q + PC_W'(pc_step);
        end
        sp_d = sp_q;
        unique case (sp_op) // RULE_06
            cpr_pkg::CPR_SP_HOLD:
            begin
                if (reg_wr && reg_addr == cpr_pkg::SEL_SP)
                begin
                    sp_d = reg_wdata;
                end
            end
            cpr_pkg::CPR_SP_PUSH: sp_d = sp_q + cpr_pkg::SP_STEP_BYTE;
            cpr_pkg::CPR_SP_POP: sp_d = sp_q - cpr_pkg::SP_STEP_BYTE;
            cpr_pkg::CPR_SP_CALL: sp_d = sp_q + cpr_pkg::SP_STEP_CALL;
            cpr_pkg::CPR_SP_RET: sp_d = sp_q - cpr_pkg::SP_STEP_CALL;
            cpr_pkg::CPR_SP_RETURN_FROM_INTERRUPT: sp_d = sp_q - cpr_pkg::SP_STEP_RETURN_FROM_INTERRUPT;
            cpr_pkg::CPR_SP_ADD: sp_d = sp_q + sp_operand;
            cpr_pkg::CPR_SP_SWAP: sp_d = sp_operand;
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pc_q <= cpr_pkg::PC_RESET;
            sp_q <= cpr_pkg::SP_RESET;
        end
        else if (clk_en)
        begin
            pc_q <= pc_d;
            sp_q <= sp_d;
        end
    end

    assign program_counter_reg = pc_q;
    assign top_of_stack_pointer = sp_q;

    // ------------------------------------------------------------------
    // Read port, indexed address, interrupt gate
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] rdata_d;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] idx_addr_d;
    logic [DATA_W-1:0] idx_addr_q;
    logic irq_take_d;
    logic irq_take_q;

    // Data stands for one cycle only, then returns to zero
    always_comb
    begin
        rdata_d = cpr_pkg::DATA_ZERO;
        if (reg_rd) // RULE_02
        begin
            unique case (reg_addr)
                cpr_pkg::SEL_ACC: rdata_d = acc_q;
                cpr_pkg::SEL_IDX: rdata_d = idx_q;
                cpr_pkg::SEL_SP: rdata_d = sp_q;
                cpr_pkg::SEL_FLAGS: rdata_d = flags_q;
                cpr_pkg::SEL_PC_LO: rdata_d = pc_q[DATA_W-1:0];
                cpr_pkg::SEL_PC_HI: rdata_d = pc_q[PC_W-1:DATA_W];
                default: rdata_d = cpr_pkg::DATA_ZERO;
            endcase
        end
        idx_addr_d = idx_q + idx_offset; // RULE_05
        irq_take_d = irq_pending && flags_q[cpr_pkg::FLAG_GIE]; // RULE_12
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rdata_q <= cpr_pkg::DATA_ZERO;
            idx_addr_q <= cpr_pkg::DATA_ZERO;
            irq_take_q <= 1'b0;
        end
        else if (clk_en)
        begin
            rdata_q <= rdata_d;
            idx_addr_q <= idx_addr_d;
            irq_take_q <= irq_take_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign idx_addr = idx_addr_q;
    assign irq_take = irq_take_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    property p_acc_result;
        clk_en && alu_wr && alu_to_acc |=> acc_q == $past(alu_result);
    endproperty
    a_acc_result: assert property (p_acc_result) else $error("accumulator missed ALU result"); // RULE_04

    property p_zero_flag;
        clk_en && alu_wr && alu_zero_en && !f_logic_wr
            |=> zero_flag == ($past(alu_result) == cpr_pkg::DATA_ZERO);
    endproperty
    a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong"); // RULE_08

    property p_carry_flag;
        clk_en && alu_wr && alu_carry_en && !f_logic_wr |=> carry_flag == $past(alu_carry);
    endproperty
    a_carry_flag: assert property (p_carry_flag) else $error("carry flag wrong"); // RULE_09

    property p_super_kept;
        clk_en && f_logic_wr && !super_enter && !super_exit |=> $stable(supervisor_state);
    endproperty
    a_super_kept: assert property (p_super_kept) else $error("user write moved supervisor bit"); // RULE_11

    property p_super_enter;
        clk_en && super_enter |=> supervisor_state ##1 (supervisor_state || $past(super_exit && clk_en));
    endproperty
    a_super_enter: assert property (p_super_enter) else $error("supervisor entry lost"); // RULE_10

    property p_flags_port_blocked;
        clk_en && reg_wr && reg_addr == cpr_pkg::SEL_FLAGS && !f_logic_wr && !alu_wr
            && !super_enter && !super_exit |=> $stable(flags_q);
    endproperty
    a_flags_port_blocked: assert property (p_flags_port_blocked) else $error("flags written by a move"); // RULE_14

    property p_reserved_zero;
        flags_q[DATA_W-1:cpr_pkg::FLAG_BANK+1] == '0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved flag bits set"); // RULE_16

    property p_reset_value;
        $fell(rst) |-> flags_q == cpr_pkg::FLAGS_RESET && acc_q == cpr_pkg::ACC_RESET && pc_q == cpr_pkg::PC_RESET;
    endproperty
    a_reset_value: assert property (@(posedge clk) p_reset_value) else $error("bad reset values"); // RULE_16

    property p_irq_gate;
        clk_en |=> irq_take == ($past(irq_pending) && $past(global_interrupt_enable));
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("interrupt not gated by enable"); // RULE_12

    property p_pc_step;
        clk_en && !pc_load |=> pc_q == $past(pc_q) + PC_W'($past(pc_step));
    endproperty
    a_pc_step: assert property (p_pc_step) else $error("program counter step wrong"); // RULE_03

    property p_sp_call;
        clk_en && sp_op == cpr_pkg::CPR_SP_CALL |=> sp_q == $past(sp_q) + cpr_pkg::SP_STEP_CALL;
    endproperty
    a_sp_call: assert property (p_sp_call) else $error("call did not move stack"); // RULE_06

    property p_index_addr;
        clk_en |=> idx_addr == $past(idx_q) + $past(idx_offset);
    endproperty
    a_index_addr: assert property (p_index_addr) else $error("indexed address wrong"); // RULE_05

    property p_freeze;
        !clk_en |=> $stable(pc_q) && $stable(flags_q) && $stable(sp_q) && $stable(acc_q);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved with clock enable low");

    c_zero_result: cover property (clk_en && alu_wr && alu_to_acc && alu_result == cpr_pkg::DATA_ZERO);
    c_logic_or: cover property (clk_en && f_logic_wr && f_logic_op == cpr_pkg::CPR_LOGIC_OR);
    c_return_from_interrupt: cover property (clk_en && sp_op == cpr_pkg::CPR_SP_RETURN_FROM_INTERRUPT);
    c_irq_taken: cover property (irq_take && register_bank_select);

endmodule

// ### common/cpr_pkg.sv
// Shared constants and types for the CPU core register set
package cpr_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int PC_W = 16;
    localparam int PROG_BYTES = 16384;
    localparam int SEL_W = 3;
    localparam int STEP_W = 2;

    // ------------------------------------------------------------------
    // Core access port selects (private to the core, not memory mapped)
    // ------------------------------------------------------------------
    localparam logic [SEL_W-1:0] SEL_ACC = 3'h0;
    localparam logic [SEL_W-1:0] SEL_IDX = 3'h1;
    localparam logic [SEL_W-1:0] SEL_SP = 3'h2;
    localparam logic [SEL_W-1:0] SEL_FLAGS = 3'h3;
    localparam logic [SEL_W-1:0] SEL_PC_LO = 3'h4;
    localparam logic [SEL_W-1:0] SEL_PC_HI = 3'h5;

    // ------------------------------------------------------------------
    // Flags register layout
    // ------------------------------------------------------------------
    localparam int FLAG_GIE = 0;
    localparam int FLAG_ZERO = 1;
    localparam int FLAG_CARRY = 2;
    localparam int FLAG_SUPER = 3;
    localparam int FLAG_BANK = 4;
    localparam logic [DATA_W-1:0] FLAGS_USER_MASK = 8'h17;
    localparam logic [DATA_W-1:0] FLAGS_IMPL_MASK = 8'h1f;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [DATA_W-1:0] FLAGS_RESET = 8'h02;
    localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
    localparam logic [DATA_W-1:0] IDX_RESET = 8'h00;
    localparam logic [DATA_W-1:0] SP_RESET = 8'h00;
    localparam logic [PC_W-1:0] PC_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;

    // ------------------------------------------------------------------
    // Stack steps
    // ------------------------------------------------------------------
    localparam logic [DATA_W-1:0] SP_STEP_BYTE = 8'h01;
    localparam logic [DATA_W-1:0] SP_STEP_CALL = 8'h02;
    localparam logic [DATA_W-1:0] SP_STEP_RETURN_FROM_INTERRUPT = 8'h03;

    // ------------------------------------------------------------------
    // Operation codes from the execution unit
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        CPR_LOGIC_AND,
        CPR_LOGIC_OR,
        CPR_LOGIC_XOR,
        CPR_LOGIC_MOV
    } cpr_logic_op_t;

    typedef enum logic [2:0] {
        CPR_SP_HOLD,
        CPR_SP_PUSH,
        CPR_SP_POP,
        CPR_SP_CALL,
        CPR_SP_RET,
        CPR_SP_RETURN_FROM_INTERRUPT,
        CPR_SP_ADD,
        CPR_SP_SWAP
    } cpr_sp_op_t;

endpackage

// ### src/cpr_hold_reg.sv
// Loadable register with clock enable, used for accumulator and index
`timescale 1ns/1ps
module cpr_hold_reg #(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic load,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    if (WIDTH < 1)
    begin : g_bad_width
        $error("cpr_hold_reg: width must be at least one bit");
    end

    logic [WIDTH-1:0] val_d;
    logic [WIDTH-1:0] val_q;

    always_comb
    begin
        val_d = load ? d : val_q;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            val_q <= RESET_VAL;
        end
        else if (clk_en)
        begin
            val_q <= val_d;
        end
    end

    assign q = val_q;

endmodule

// ### tb/cpr_alu_model.sv
// Behavioural adder that stands in for the execution unit's ALU
`timescale 1ns/1ps
module cpr_alu_model (
    input wire logic [7:0] acc,
    input wire logic [7:0] operand,
    output logic [7:0] result,
    output logic carry
);
    // Combinational like the real datapath, so the result settles before the strobe edge
    assign {carry, result} = {1'b0, acc} + {1'b0, operand};
endmodule

// ### tb/cpr_core_regs_tb.sv
// Self-checking bench for the core register set
`timescale 1ns/1ps
module cpr_core_regs_tb;
    logic clk, rst, clk_en, reg_wr, reg_rd, alu_wr, alu_to_acc, alu_zero_en, alu_carry_en, alu_carry;
    logic f_logic_wr, super_enter, super_exit, pc_load, irq_pending, irq_take;
    logic gie, bank, zf, cf, sup;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, alu_result, alu_b, f_operand, sp_operand, idx_offset, idx_addr;
    logic [7:0] sp, acc, idx, flags, rv;
    logic [15:0] pc_target, pc;
    logic [1:0] pc_step;
    cpr_pkg::cpr_logic_op_t f_logic_op;
    cpr_pkg::cpr_sp_op_t sp_op;
    int failures = 0;
    int checks_done = 0;
    int cycles = 0;

    cpr_core_regs cpr_core_regs_i (.clk(clk), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .alu_wr(alu_wr),
        .alu_to_acc(alu_to_acc), .alu_zero_en(alu_zero_en), .alu_carry_en(alu_carry_en),
        .alu_result(alu_result), .alu_carry(alu_carry), .f_logic_wr(f_logic_wr), .f_logic_op(f_logic_op),
        .f_operand(f_operand), .super_enter(super_enter), .super_exit(super_exit), .pc_load(pc_load),
        .pc_target(pc_target), .pc_step(pc_step), .sp_op(sp_op), .sp_operand(sp_operand),
        .idx_offset(idx_offset), .idx_addr(idx_addr), .irq_pending(irq_pending), .irq_take(irq_take),
        .program_counter_reg(pc), .top_of_stack_pointer(sp), .result_accumulator(acc),
        .index_offset(idx), .processor_flags(flags), .global_interrupt_enable(gie),
        .register_bank_select(bank), .zero_flag(zf), .carry_flag(cf), .supervisor_state(sup));

    cpr_alu_model cpr_alu_model_i (.acc(acc), .operand(alu_b), .result(alu_result), .carry(alu_carry));

    // ------------------------------------------------------------------
    // Clock, timeout and closing
    // ------------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic report_and_stop;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Whole sequence needs about 80 cycles; the margin covers a stuck handshake
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            failures++;
            report_and_stop();
        end
    end

    // ------------------------------------------------------------------
    // Drivers and comparison
    // ------------------------------------------------------------------
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        checks_done++;
        if (s !== e)
        begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, s, e);
        end
    endtask

    task automatic done(input string n);
        $display("test %s finished", n);
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe, so sample right there
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic alu(input logic [7:0] b, input logic ta, input logic ze, input logic ce);
        @(posedge clk);
        alu_b <= b;
        alu_to_acc <= ta;
        alu_zero_en <= ze;
        alu_carry_en <= ce;
        alu_wr <= 1'b1;
        @(posedge clk);
        alu_wr <= 1'b0;
        #1;
    endtask

    task automatic flog(input cpr_pkg::cpr_logic_op_t op, input logic [7:0] v);
        @(posedge clk);
        f_logic_op <= op;
        f_operand <= v;
        f_logic_wr <= 1'b1;
        @(posedge clk);
        f_logic_wr <= 1'b0;
        #1;
    endtask

    task automatic spop(input cpr_pkg::cpr_sp_op_t op, input logic [7:0] v);
        @(posedge clk);
        sp_op <= op;
        sp_operand <= v;
        @(posedge clk);
        sp_op <= cpr_pkg::CPR_SP_HOLD;
        #1;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        chk(flags, 16'h0002);
        chk({acc, idx}, 16'h0000);
        chk(pc, 16'h0000);
        chk({sp, reg_rdata}, 16'h0000);
        chk({irq_take, zf, gie}, 16'h0002);
        done("reset");
    endtask

    task automatic t_access;
        wr(3'h0, 8'h5a);
        chk(acc, 16'h005a);
        rd(3'h0, rv);
        chk(rv, 16'h005a);
        @(posedge clk);
        #1 chk(reg_rdata, 16'h0000);
        rd(3'h6, rv);
        chk(rv, 16'h0000);
        wr(3'h4, 8'h77);
        chk(pc, 16'h0000);
        done("access");
    endtask

    task automatic t_alu;
        wr(3'h0, 8'h01);
        alu(8'hff, 1'b1, 1'b1, 1'b1);
        chk({acc, zf, cf}, 16'h0003);
        alu(8'h02, 1'b1, 1'b1, 1'b1);
        chk({acc, zf, cf}, 16'h0008);
        // Destination mode: flags move, accumulator and carry must not
        alu(8'hfe, 1'b0, 1'b1, 1'b0);
        chk({acc, zf, cf}, 16'h000a);
        done("alu");
    endtask

    task automatic t_flags;
        cpr_pkg::cpr_logic_op_t ops[4];
        logic [7:0] opv[4];
        logic [7:0] res[4];
        ops = '{cpr_pkg::CPR_LOGIC_MOV, cpr_pkg::CPR_LOGIC_AND, cpr_pkg::CPR_LOGIC_OR, cpr_pkg::CPR_LOGIC_XOR};
        opv = '{8'hff, 8'hee, 8'h11, 8'h16};
        res = '{8'h17, 8'h06, 8'h17, 8'h01};
        wr(3'h3, 8'hff);
        chk(flags, 16'h0002);
        for (int i = 0; i < 4; i++)
        begin
            flog(ops[i], opv[i]);
            chk(flags, {8'h00, res[i]});
        end
        @(posedge clk);
        irq_pending <= 1'b1;
        @(posedge clk);
        #1 chk(irq_take, 16'h0001);
        flog(cpr_pkg::CPR_LOGIC_MOV, 8'h10);
        @(posedge clk);
        #1 chk({irq_take, bank, gie}, 16'h0002);
        @(posedge clk);
        irq_pending <= 1'b0;
        done("flags");
    endtask

    task automatic t_super;
        @(posedge clk);
        super_enter <= 1'b1;
        @(posedge clk);
        super_enter <= 1'b0;
        #1 chk({sup, flags}, 16'h0118);
        flog(cpr_pkg::CPR_LOGIC_MOV, 8'h00);
        chk(flags, 16'h0008);
        @(posedge clk);
        super_exit <= 1'b1;
        @(posedge clk);
        super_exit <= 1'b0;
        #1 chk({sup, flags}, 16'h0000);
        done("super");
    endtask

    task automatic t_pc;
        @(posedge clk);
        pc_target <= 16'h3ffe;
        pc_load <= 1'b1;
        @(posedge clk);
        pc_load <= 1'b0;
        pc_step <= 2'h1;
        @(posedge clk);
        pc_step <= 2'h0;
        #1 chk(pc, 16'h3fff);
        rd(3'h4, rv);
        chk(rv, 16'h00ff);
        rd(3'h5, rv);
        chk(rv, 16'h003f);
        // Frozen clock enable must hold the counter even with a step requested
        @(posedge clk);
        clk_en <= 1'b0;
        pc_step <= 2'h2;
        repeat (3) @(posedge clk);
        clk_en <= 1'b1;
        pc_step <= 2'h0;
        #1 chk(pc, 16'h3fff);
        done("pc");
    endtask

    task automatic t_sp;
        cpr_pkg::cpr_sp_op_t ops[7];
        logic [7:0] res[7];
        ops = '{cpr_pkg::CPR_SP_PUSH, cpr_pkg::CPR_SP_CALL, cpr_pkg::CPR_SP_ADD, cpr_pkg::CPR_SP_RETURN_FROM_INTERRUPT,
                cpr_pkg::CPR_SP_RET, cpr_pkg::CPR_SP_POP, cpr_pkg::CPR_SP_SWAP};
        res = '{8'h01, 8'h03, 8'h13, 8'h10, 8'h0e, 8'h0d, 8'h80};
        for (int i = 0; i < 7; i++)
        begin
            spop(ops[i], (i == 6) ? 8'h80 : 8'h10);
            chk(sp, {8'h00, res[i]});
        end
        rd(3'h2, rv);
        chk(rv, 16'h0080);
        wr(3'h2, 8'h42);
        chk(sp, 16'h0042);
        done("sp");
    endtask

    task automatic t_idx;
        @(posedge clk);
        idx_offset <= 8'h20;
        wr(3'h1, 8'hf0);
        @(posedge clk);
        #1 chk(idx_addr, 16'h0010);
        rd(3'h1, rv);
        chk(rv, 16'h00f0);
        done("index");
    endtask

    // Reset in mid-run must bring flags, accumulator, index and stack pointer back, zero flag set
    task automatic t_midreset;
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        #1;
        chk({flags, acc}, 16'h0200);
        chk({sp, idx}, 16'h0000);
        chk({irq_take, reg_rdata}, 16'h0000);
        done("midreset");
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        rst = 1'b1;
        clk_en = 1'b1;
        {reg_wr, reg_rd, alu_wr, alu_to_acc, alu_zero_en, alu_carry_en} = '0;
        {f_logic_wr, super_enter, super_exit, pc_load, irq_pending} = '0;
        reg_addr = 3'h0;
        {reg_wdata, alu_b, f_operand, sp_operand, idx_offset} = '0;
        pc_target = 16'h0000;
        pc_step = 2'h0;
        f_logic_op = cpr_pkg::CPR_LOGIC_MOV;
        sp_op = cpr_pkg::CPR_SP_HOLD;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        t_reset();
        t_access();
        t_alu();
        t_flags();
        t_super();
        t_pc();
        t_sp();
        t_idx();
        t_midreset();
        report_and_stop();
    end
endmodule
